// ### tbb_break_gen.v
// breakpoint request generation and routing to core or background port
`default_nettype none
module tbb_break_gen (
  input wire ref_clk,
  input wire rst_b,
  input wire en,
  input wire cmode_dupsup,
  input wire cmode_profile,
  input wire ab_hit,
  input wire ab_tag,
  input wire c_match,
  input wire c_en,
  input wire c_tag,
  input wire bkgd_sel,
  input wire ext_tag,
  output reg brk_tag_q,
  output reg brk_force_q,
  output reg swi_req_q,
  output reg bdm_req_q
);
  wire c_hit;
  wire tag_d;
  wire force_d;
  wire any_d;

  // comparator c acts independent of a/b mode, muted in dup-suppress and profile modes
  assign c_hit = en & c_en & c_match & ~cmode_dupsup & ~cmode_profile;
  // external tag pins count only while the unit is off
  assign tag_d = (ab_hit & ab_tag) | (c_hit & c_tag) | (~en & ext_tag);
  assign force_d = (ab_hit & ~ab_tag) | (c_hit & ~c_tag);
  assign any_d = tag_d | force_d;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      brk_tag_q <= 1'b0;
      brk_force_q <= 1'b0;
      swi_req_q <= 1'b0;
      bdm_req_q <= 1'b0;
    end else begin
      brk_tag_q <= tag_d;
      brk_force_q <= force_d;
      swi_req_q <= any_d & ~bkgd_sel;
      bdm_req_q <= any_d & bkgd_sel;
    end
  end
endmodule // tbb_break_gen
`default_nettype wire

// ### tbb_checker.sv
// port assertions of the trace unit
`include "tbb_map.vh"
`default_nettype none
module tbb_checker (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata_q,
  input wire logic trig_in,
  input wire logic trace_valid,
  input wire logic c_match,
  input wire logic trace_armed_q,
  input wire logic brk_tag_q,
  input wire logic brk_force_q,
  input wire logic software_interrupt_q,
  input wire logic background_debug_port_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire logic brk = brk_tag_q | brk_force_q;
  wire logic req = software_interrupt_q | background_debug_port_q;
  wire logic arm_wr = reg_wr && reg_addr == `TBB_OFS_CTL1 && reg_wdata[`TBB_C1_EN] && reg_wdata[`TBB_C1_ARM];
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata_q == 16'h0000)
    else $error("read data outside read slot");
  AST_ARMED_READ: assert property (reg_rd && reg_addr == `TBB_OFS_WIN && trace_armed_q |=> reg_rdata_q == 16'h0000)
    else $error("armed window read gave data");
  AST_TYPE_ONE: assert property (!(brk_tag_q && brk_force_q))
    else $error("tagged and forced together");
  AST_ROUTE_ONE: assert property (!(software_interrupt_q && background_debug_port_q))
    else $error("both routes at once");
  AST_BRK_ROUTED: assert property (brk |-> req)
    else $error("break without route");
  AST_REQ_CAUSE: assert property (req |-> brk)
    else $error("route without break");
  AST_ARM_SW: assert property ($rose(trace_armed_q) |-> $past(arm_wr))
    else $error("armed without arming write");
  AST_DISARM_CAUSE: assert property ($fell(trace_armed_q) |-> $past(trig_in) || $past(reg_wr) || $past(trace_valid))
    else $error("disarm without cause");
  AST_C_KEEPS_ARM: assert property (c_match && trace_armed_q && !trig_in && !trace_valid && !reg_wr |=> trace_armed_q)
    else $error("comparator c changed armed");
  COV_TAG: cover property (brk_tag_q);
  COV_FORCE: cover property (brk_force_q && software_interrupt_q);
  COV_BDM: cover property (background_debug_port_q);
endmodule // tbb_checker
`default_nettype wire

// ### tbb_core_model.sv
// core and background port model: counts the requests it takes
`default_nettype none
module tbb_core_model (
  input wire logic ref_clk,
  input wire logic brk_tag_q,
  input wire logic brk_force_q,
  input wire logic software_interrupt_q,
  input wire logic background_debug_port_q,
  output var logic [7:0] n_swi,
  output var logic [7:0] n_bdm
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    n_swi = 8'h00;
    n_bdm = 8'h00;
  end
  always @(posedge ref_clk) begin
    if ((brk_tag_q | brk_force_q) && software_interrupt_q) n_swi <= n_swi + 8'h01;
    if ((brk_tag_q | brk_force_q) && background_debug_port_q) n_bdm <= n_bdm + 8'h01;
  end
endmodule // tbb_core_model
`default_nettype wire

// ### tbb_map.vh
// register offsets, field positions, reset values and sizes of the trace unit
`ifndef TBB_MAP_VH
`define TBB_MAP_VH

`define TBB_OFS_CTL1 4'h0
`define TBB_OFS_CTL2 4'h1
`define TBB_OFS_CNT 4'h2
`define TBB_OFS_WIN 4'h3

`define TBB_C1_EN 7
`define TBB_C1_ARM 6
`define TBB_C1_ABBRK 5
`define TBB_C1_BEGIN 4
`define TBB_C1_TSEL 3
`define TBB_C1_EVO 2

`define TBB_C2_CEN 7
`define TBB_C2_CTAG 6
`define TBB_C2_BKGD 5
`define TBB_C2_MODE_HI 1
`define TBB_C2_MODE_LO 0

`define TBB_MODE_NORMAL 2'h0
`define TBB_MODE_DUPSUP 2'h1
`define TBB_MODE_DETAIL 2'h2
`define TBB_MODE_PROFILE 2'h3

`define TBB_CNT_ARMED 15
`define TBB_CNT_TRIG 14

`define TBB_RST_CTL1 8'h00
`define TBB_RST_CTL2 8'h00
`define TBB_DEPTH 64
`define TBB_AW 6
`define TBB_DW 16

`endif

// ### tbb_trace_ram.v
// trace storage memory with registered read data
`default_nettype none
module tbb_trace_ram #(
  parameter AW = 6,
  parameter DW = 16
) (
  input wire ref_clk,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata_q
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule // tbb_trace_ram
`default_nettype wire

// ### tbb_trace_unit.v
// trace unit: end/begin trigger storage, trace readout window, breakpoints
//
// Local design decisions: strobed register access and the register offsets.
`include "tbb_map.vh"
`default_nettype none
// What this block does
// - event-only trigger never uses end-trigger storage
// - end-trigger stores until trigger, then disarms
// - end-trigger: triggering change-of-flow entry not stored
// - readout only enabled and disarmed, oldest first
// - valid count does not drop on reads
// - each enabled, disarmed window read advances read pointer
// - armed window read: undefined data, pointer held
// - external tag pins ignored while enabled
// - a/b break needs a/b break enable
// - begin-trigger break after 64 words stored
// - end-trigger break at the trigger
// - tag select in end mode: 1 tagged, 0 forced
// - tagged halts before opcode, forced at boundary
// - begin, tagged, enabled: forced break when full
// - break enable off: capture, no break
// - comparator c breaks, armed flag untouched
// - c tag select picks tagged or forced
// - no comparator c break in dup-suppress mode
// - break enables locked while armed
// - reset leaves unit disabled, never resets system
// - background select clear: software interrupt
// - begin-trigger stays armed until 64 stored
module tbb_trace_unit #(
  parameter AW = `TBB_AW,
  parameter DW = `TBB_DW
) (
  input wire ref_clk,
  input wire rst_b,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata_q,
  input wire trig_in,
  input wire trig_cof,
  input wire trace_valid,
  input wire [DW-1:0] trace_data,
  input wire c_match,
  input wire external_tag_high_pin,
  input wire external_tag_low_pin,
  output reg trace_armed_q,
  output wire brk_tag_q,
  output wire brk_force_q,
  output wire software_interrupt_q,
  output wire background_debug_port_q
);
  // a full buffer shows the top count bit alone
  localparam [AW:0] FULL_CNT = {1'b1, {AW{1'b0}}};
  localparam [AW:0] LAST_CNT = FULL_CNT - 1'b1;

  // control fields
  reg en_q;
  reg abbrk_q;
  reg begin_q;
  reg tsel_q;
  reg evo_q;
  reg cen_q;
  reg ctag_q;
  reg bkgd_q;
  reg [1:0] cmode_q;

  // capture state
  reg trig_seen_q;
  reg [AW-1:0] wp_q;
  reg [AW:0] cnt_q;
  reg [AW-1:0] rofs_q;

  // external tag pin synchronisers
  reg tag_hi_s1_q;
  reg tag_hi_s2_q;
  reg tag_lo_s1_q;
  reg tag_lo_s2_q;

  wire [DW-1:0] ram_q;
  wire [AW-1:0] raddr;
  wire [AW-1:0] oldest;
  wire begin_eff;
  wire cap_ok;
  wire end_trig;
  wire store;
  wire full_hit;
  wire ab_hit;
  wire ab_tag;
  wire win_rd;
  wire wr_c1;
  wire wr_c2;
  wire arm_req;
  wire ext_tag;

  function hit;
    input [3:0] a;
    input [3:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // event-only trigger modes always behave as begin-trigger
  assign begin_eff = begin_q | evo_q;

  assign cap_ok = en_q & trace_armed_q & (cmode_q != `TBB_MODE_PROFILE);

  assign end_trig = cap_ok & ~begin_eff & trig_in;

  // end mode: store until trigger, skip the triggering change-of-flow word
  // begin mode: store from the trigger word on
  assign store = cap_ok & trace_valid & (begin_eff ?
                 (trig_seen_q | trig_in) :
                 ~(trig_in & trig_cof));

  assign full_hit = store & begin_eff & (cnt_q == LAST_CNT);

  // a/b requests only with break enable set
  assign ab_hit = abbrk_q & (end_trig | full_hit);
  // a request from a full buffer in begin mode is always forced, never tagged
  assign ab_tag = tsel_q & ~begin_eff;

  assign ext_tag = tag_hi_s2_q | tag_lo_s2_q;

  assign wr_c1 = reg_wr & hit(reg_addr, `TBB_OFS_CTL1);
  assign wr_c2 = reg_wr & hit(reg_addr, `TBB_OFS_CTL2);

  assign arm_req = wr_c1 & reg_wdata[`TBB_C1_ARM] & reg_wdata[`TBB_C1_EN] & ~trace_armed_q;

  // readout only while enabled and disarmed
  assign win_rd = reg_rd & hit(reg_addr, `TBB_OFS_WIN) & en_q & ~trace_armed_q;

  // a wrapped buffer starts at the write pointer, else at zero
  assign oldest = cnt_q[AW] ? wp_q : {AW{1'b0}};

  // look ahead one word on a window read so back-to-back reads keep up
  assign raddr = oldest + rofs_q + {{(AW-1){1'b0}}, win_rd};

  tbb_trace_ram #(
    .AW(AW),
    .DW(DW)
  ) u_ram (
    .ref_clk(ref_clk),
    .we(store),
    .waddr(wp_q),
    .wdata(trace_data),
    .raddr(raddr),
    .rdata_q(ram_q)
  );

  tbb_break_gen u_brk (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .en(en_q),
    .cmode_dupsup(cmode_q == `TBB_MODE_DUPSUP),
    .cmode_profile(cmode_q == `TBB_MODE_PROFILE),
    .ab_hit(ab_hit),
    .ab_tag(ab_tag),
    .c_match(c_match),
    .c_en(cen_q),
    .c_tag(ctag_q),
    .bkgd_sel(bkgd_q),
    .ext_tag(ext_tag),
    .brk_tag_q(brk_tag_q),
    .brk_force_q(brk_force_q),
    .swi_req_q(software_interrupt_q),
    .bdm_req_q(background_debug_port_q)
  );

  // tag pins come from outside the clock domain
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tag_hi_s1_q <= 1'b0;
      tag_hi_s2_q <= 1'b0;
      tag_lo_s1_q <= 1'b0;
      tag_lo_s2_q <= 1'b0;
    end else begin
      tag_hi_s1_q <= external_tag_high_pin;
      tag_hi_s2_q <= tag_hi_s1_q;
      tag_lo_s1_q <= external_tag_low_pin;
      tag_lo_s2_q <= tag_lo_s1_q;
    end
  end

  // control registers; break settings are frozen while armed
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q <= 1'b0;
      abbrk_q <= 1'b0;
      begin_q <= 1'b0;
      tsel_q <= 1'b0;
      evo_q <= 1'b0;
      cen_q <= 1'b0;
      ctag_q <= 1'b0;
      bkgd_q <= 1'b0;
      cmode_q <= `TBB_MODE_NORMAL;
    end else begin
      if (wr_c1) begin
        en_q <= reg_wdata[`TBB_C1_EN];
      end
      if (wr_c1 & ~trace_armed_q) begin
        abbrk_q <= reg_wdata[`TBB_C1_ABBRK];
        begin_q <= reg_wdata[`TBB_C1_BEGIN];
        tsel_q <= reg_wdata[`TBB_C1_TSEL];
        evo_q <= reg_wdata[`TBB_C1_EVO];
      end
      if (wr_c2 & ~trace_armed_q) begin
        cen_q <= reg_wdata[`TBB_C2_CEN];
        ctag_q <= reg_wdata[`TBB_C2_CTAG];
        bkgd_q <= reg_wdata[`TBB_C2_BKGD];
        cmode_q <= reg_wdata[`TBB_C2_MODE_HI:`TBB_C2_MODE_LO];
      end
    end
  end

  // armed flag: software arms, trigger or full buffer disarms
  // comparator c plays no part here
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      trace_armed_q <= 1'b0;
    end else begin
      if (end_trig | full_hit) begin
        trace_armed_q <= 1'b0;
      end
      if (wr_c1) begin
        if (~reg_wdata[`TBB_C1_EN] | ~reg_wdata[`TBB_C1_ARM]) begin
          trace_armed_q <= 1'b0;
        end else if (arm_req) begin
          trace_armed_q <= 1'b1;
        end
      end
    end
  end

  // write pointer, valid count and begin-trigger latch
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_seen_q <= 1'b0;
      wp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else if (arm_req) begin
      trig_seen_q <= 1'b0;
      wp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (cap_ok & begin_eff & trig_in) begin
        trig_seen_q <= 1'b1;
      end
      if (store) begin
        wp_q <= wp_q + 1'b1;
        if (cnt_q != FULL_CNT) begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  // read offset: only a legal window read advances it and arming clears it; reads never move the count
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rofs_q <= {AW{1'b0}};
    end else if (arm_req) begin
      rofs_q <= {AW{1'b0}};
    end else if (win_rd) begin
      rofs_q <= rofs_q + 1'b1;
    end
  end

  // read data, valid only in the cycle after the strobe
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= 16'h0000;
    end else if (!reg_rd) begin
      reg_rdata_q <= 16'h0000;
    end else begin
      case (reg_addr)
        `TBB_OFS_CTL1: begin
          reg_rdata_q <= {8'h00, en_q, trace_armed_q, abbrk_q, begin_q,
                          tsel_q, evo_q, 2'h0};
        end
        `TBB_OFS_CTL2: begin
          reg_rdata_q <= {8'h00, cen_q, ctag_q, bkgd_q, 3'h0, cmode_q};
        end
        `TBB_OFS_CNT: begin
          reg_rdata_q <= {trace_armed_q, trig_seen_q, {(14-AW-1){1'b0}}, cnt_q};
        end
        `TBB_OFS_WIN: begin
          // armed or disabled reads give zero as the undefined value
          reg_rdata_q <= win_rd ? ram_q : 16'h0000;
        end
        default: begin
          reg_rdata_q <= 16'h0000;
        end
      endcase
    end
  end
endmodule // tbb_trace_unit
`default_nettype wire

// ### trace_buffer_breakpoint_unit_tb.sv
// testbench of the trace unit
`include "tbb_map.vh"
`default_nettype none
module trace_buffer_breakpoint_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, trig_in = 1'b0, trig_cof = 1'b0;
  logic trace_valid = 1'b0, c_match = 1'b0, tag_pin = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, trace_data = 16'h0000;
  wire logic [15:0] reg_rdata_q;
  wire logic armed, bt, bf, software_interrupt, background_debug_port;
  wire logic [7:0] n_swi, n_bdm;
  int failures = 0, n_checks = 0, e_swi = 0, e_bdm = 0;
  logic [7:0] c2_row [8] = '{8'hC0, 8'h80, 8'hA0, 8'hE0, 8'h81, 8'h40, 8'h83, 8'h82};
  logic [3:0] c_exp [8] = '{4'hA, 4'h6, 4'h5, 4'h9, 4'h0, 4'h0, 4'h0, 4'h6};
  always #50 ref_clk = ~ref_clk;
  tbb_trace_unit dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .trig_in(trig_in), .trig_cof(trig_cof),
    .trace_valid(trace_valid), .trace_data(trace_data), .c_match(c_match), .external_tag_high_pin(tag_pin),
    .external_tag_low_pin(tag_pin), .trace_armed_q(armed), .brk_tag_q(bt), .brk_force_q(bf),
    .software_interrupt_q(software_interrupt), .background_debug_port_q(background_debug_port));
  tbb_core_model core_u (.ref_clk(ref_clk), .brk_tag_q(bt), .brk_force_q(bf), .software_interrupt_q(software_interrupt),
    .background_debug_port_q(background_debug_port), .n_swi(n_swi), .n_bdm(n_bdm));
  task automatic test_done;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what, input logic [15:0] m = 16'hFFFF);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(what, exp, reg_rdata_q & m);
  endtask
  // expected order {tagged, forced, interrupt, background}
  task automatic chk_req(input logic [3:0] e);
    chk("requests", {12'h000, e}, {12'h000, bt, bf, software_interrupt, background_debug_port});
    e_swi += e[1];
    e_bdm += e[0];
  endtask
  // three words then a trigger word; f is the first stored word, n the stored count
  task automatic end_run(input logic [15:0] c1, input logic cof, input logic [3:0] e, input logic arm_e,
    input int f, input int n);
    wr(`TBB_OFS_CTL1, c1);
    wr(`TBB_OFS_CTL1, 16'h00C0);
    rd(`TBB_OFS_WIN, 16'h0000, "armed window");
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      trace_valid <= 1'b1;
      trace_data <= 16'h0A00 + 16'(i);
      trig_in <= (i == 3);
      trig_cof <= cof;
      c_match <= (i == 0);
    end
    @(posedge ref_clk);
    trace_valid <= 1'b0;
    trig_in <= 1'b0;
    #1 chk_req(e);
    chk("armed", {15'h0000, arm_e}, {15'h0000, armed});
    wr(`TBB_OFS_CTL1, 16'h0080);
    rd(`TBB_OFS_CNT, 16'(n), "count", 16'h007F);
    for (int i = 0; i < n; i++) rd(`TBB_OFS_WIN, 16'h0A00 + 16'(f + i), "window");
    rd(`TBB_OFS_CNT, 16'(n), "count after reads", 16'h007F);
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1 chk("reset outputs", 16'h0000, {11'h000, armed, bt, bf, software_interrupt, background_debug_port});
    rd(`TBB_OFS_CTL1, 16'h0000, "ctl1 reset");
    rd(`TBB_OFS_CTL2, 16'h0000, "ctl2 reset");
    rd(`TBB_OFS_CNT, 16'h0000, "count reset");
    rd(4'hF, 16'h0000, "unmapped");
    wr(`TBB_OFS_CTL1, 16'h0080);
    for (int r = 0; r < 8; r++) begin
      wr(`TBB_OFS_CTL2, {8'h00, c2_row[r]});
      @(posedge ref_clk);
      c_match <= 1'b1;
      @(posedge ref_clk);
      c_match <= 1'b0;
      #1 chk_req(c_exp[r]);
    end
    wr(`TBB_OFS_CTL2, 16'h0000);
    end_run(16'h00E0, 1'b1, 4'h6, 1'b0, 0, 3);
    end_run(16'h00E8, 1'b0, 4'hA, 1'b0, 0, 4);
    end_run(16'h00C0, 1'b0, 4'h0, 1'b0, 0, 4);
    end_run(16'h00C4, 1'b0, 4'h0, 1'b1, 3, 1);
    wr(`TBB_OFS_CTL1, 16'h00F8);
    for (int i = 0; i <= 64; i++) begin
      @(posedge ref_clk);
      trace_valid <= (i < 64);
      trace_data <= 16'h5000 + 16'(i);
      trig_in <= (i == 0);
      #1 if (i > 0) chk("begin run", (i == 64) ? 16'h0006 : 16'h0010, {11'h000, armed, bt, bf, software_interrupt, background_debug_port});
    end
    e_swi++;
    wr(`TBB_OFS_CTL1, 16'h0080);
    rd(`TBB_OFS_WIN, 16'h5000, "begin first word");
    rd(`TBB_OFS_WIN, 16'h5001, "begin second word");
    rd(`TBB_OFS_CNT, 16'h0040, "begin count", 16'h007F);
    @(posedge ref_clk);
    tag_pin <= 1'b1;
    repeat (6) begin
      @(posedge ref_clk);
      #1 chk("tag pin enabled", 16'h0000, {14'h0000, bt, software_interrupt});
    end
    @(posedge ref_clk);
    tag_pin <= 1'b0;
    repeat (3) @(posedge ref_clk);
    wr(`TBB_OFS_CTL1, 16'h0000);
    @(posedge ref_clk);
    tag_pin <= 1'b1;
    @(posedge ref_clk);
    tag_pin <= 1'b0;
    // two synchroniser stages, then the registered request
    repeat (2) @(posedge ref_clk);
    #1 chk("tag pin disabled", 16'h0003, {14'h0000, bt, software_interrupt});
    e_swi++;
    repeat (4) @(posedge ref_clk);
    chk("interrupt count", 16'(e_swi), {8'h00, n_swi});
    chk("background count", 16'(e_bdm), {8'h00, n_bdm});
    wr(`TBB_OFS_CTL1, 16'h00C0);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1 chk("mid-run reset outputs", 16'h0000, {11'h000, armed, bt, bf, software_interrupt, background_debug_port});
    rd(`TBB_OFS_CTL1, 16'h0000, "ctl1 after mid-run reset");
    rd(`TBB_OFS_CNT, 16'h0000, "count after mid-run reset");
    test_done();
  end
  initial begin
    #2000000;
    failures++;
    test_done();
  end
endmodule // trace_buffer_breakpoint_unit_tb
bind tbb_trace_unit tbb_checker chk_u (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .trig_in(trig_in),
  .trace_valid(trace_valid), .c_match(c_match), .trace_armed_q(trace_armed_q), .brk_tag_q(brk_tag_q),
  .brk_force_q(brk_force_q), .software_interrupt_q(software_interrupt_q),
  .background_debug_port_q(background_debug_port_q));
`default_nettype wire
